// ### sbcwd_pkg.sv
/*
 Shared constants, codes and helper functions of the watchdog supervisor.
 Assumes a 100 MHz system clock; register access is a plain byte-wide port.
*/
`default_nettype none
package sbcwd_pkg;
   // Register addresses
   localparam logic [6:0] ADDR_WD_CTRL = 7'h00;
   localparam logic [6:0] ADDR_WD_STAT = 7'h05;
   localparam logic [6:0] ADDR_NV_CFG  = 7'h74;
   // Control register fields
   localparam int MODE_LSB = 5;
   localparam int PER_LSB  = 0;
   // Redundant codes: every valid pair differs in at least two bits
   localparam logic [2:0] MODE_AUTO = 3'h1;
   localparam logic [2:0] MODE_TMO  = 3'h2;
   localparam logic [2:0] MODE_WIN  = 3'h4;
   localparam logic [3:0] PER_8     = 4'h8;
   localparam logic [3:0] PER_16    = 4'h1;
   localparam logic [3:0] PER_32    = 4'h2;
   localparam logic [3:0] PER_64    = 4'hb;
   localparam logic [3:0] PER_128   = 4'h4;
   localparam logic [3:0] PER_256   = 4'hd;
   localparam logic [3:0] PER_1024  = 4'he;
   localparam logic [3:0] PER_4096  = 4'h7;
   // Non-volatile configuration fields and factory presets
   localparam int NV_UV_LSB = 4;
   localparam int NV_FN_BIT = 3;
   localparam int NV_SD_BIT = 2;
   localparam int NV_SLP_BIT = 0;
   localparam logic [7:0] NV_PRESET = 8'h08;
   localparam logic [7:0] NV_WR_MASK = 8'h3d;
   localparam logic [1:0] UV_90PCT = 2'h0;
   // Reset causes
   localparam logic [4:0] CAUSE_POWER   = 5'h00;
   localparam logic [4:0] CAUSE_SLP_OVF = 5'h0c;
   localparam logic [4:0] CAUSE_EARLY   = 5'h0e;
   localparam logic [4:0] CAUSE_OVF     = 5'h0f;
   localparam logic [4:0] CAUSE_ILLEGAL = 5'h10;
   // Phase status codes
   localparam logic [1:0] WDS_OFF   = 2'h0;
   localparam logic [1:0] WDS_FIRST = 2'h1;
   localparam logic [1:0] WDS_SECOND = 2'h2;
   // Timing
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned MS_IN_NS = 1000000;
   localparam int unsigned CYC_PER_MS_DFLT = MS_IN_NS / CLK_PERIOD_NS;
   localparam int PERIOD_W = 13;

   typedef enum logic [1:0] {
      SBCWD_NORMAL  = 2'h0,
      SBCWD_STANDBY = 2'h1,
      SBCWD_SLEEP   = 2'h2,
      SBCWD_OTHER   = 2'h3
   } sbcwd_sbc_mode_t;

   typedef enum logic [2:0] {
      SBCWD_OFF = 3'b001,
      SBCWD_TMO = 3'b010,
      SBCWD_WIN = 3'b100
   } sbcwd_behav_t;

   function automatic logic sbcwd_mode_ok(input logic [2:0] m);
      return (m == MODE_AUTO) || (m == MODE_TMO) || (m == MODE_WIN);
   endfunction

   // Period in ms, zero for a code that is not permitted
   function automatic logic [PERIOD_W-1:0] sbcwd_period_ms(input logic [3:0] p);
      case (p)
         PER_8:    return 13'd8;
         PER_16:   return 13'd16;
         PER_32:   return 13'd32;
         PER_64:   return 13'd64;
         PER_128:  return 13'd128;
         PER_256:  return 13'd256;
         PER_1024: return 13'd1024;
         PER_4096: return 13'd4096;
         default:  return 13'd0;
      endcase
   endfunction
endpackage
`default_nettype wire

// ### sbcwd_timer.sv
/*
 Watchdog period timer: millisecond prescaler and period counter.
 Assumes period_ms_i is a valid nonzero period while run_i is high.
*/
`timescale 1ns/1ns
`default_nettype none
module sbcwd_timer
   import sbcwd_pkg::*;
#(
   parameter int unsigned CYC_PER_MS = CYC_PER_MS_DFLT
)(
   input  wire logic                clk_sys_i,
   input  wire logic                rst_n_i,
   input  wire logic                run_i,
   input  wire logic                restart_i,
   input  wire logic [PERIOD_W-1:0] period_ms_i,
   output logic                     ovf_o,
   output logic                     second_half_o,
   output logic [PERIOD_W-1:0]      ms_cnt_o
);
   logic [31:0] pre;
   logic        tick;

   assign tick = (pre == 32'(CYC_PER_MS - 1));
   assign second_half_o = (ms_cnt_o >= (period_ms_i >> 1));

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pre      <= 32'h0;
         ms_cnt_o <= 13'h0;
         ovf_o    <= 1'b0;
      end
      else if (!run_i || restart_i)
      begin
         pre      <= 32'h0;
         ms_cnt_o <= 13'h0;
         ovf_o    <= 1'b0;
      end
      else if (tick)
      begin
         pre <= 32'h0;
         // Wraps on expiry so the timer keeps running
         if (ms_cnt_o == period_ms_i - 13'h1)
         begin
            ms_cnt_o <= 13'h0;
            ovf_o    <= 1'b1;
         end
         else
         begin
            ms_cnt_o <= ms_cnt_o + 13'h1;
            ovf_o    <= 1'b0;
         end
      end
      else
      begin
         pre   <= pre + 32'h1;
         ovf_o <= 1'b0;
      end
   end
endmodule // sbcwd_timer
`default_nettype wire

// ### sbcwd_nvcfg.sv
/*
 Non-volatile start-up configuration register.
 Assumes nv_rst_n_i is asserted only at power-on, not on system resets.
*/
`timescale 1ns/1ns
`default_nettype none
module sbcwd_nvcfg
   import sbcwd_pkg::*;
#(
   parameter bit LOW_VOLT_VARIANT = 1'b0
)(
   input  wire logic       clk_sys_i,
   input  wire logic       nv_rst_n_i,
   input  wire logic       wr_i,
   input  wire logic [7:0] wdata_i,
   output logic [7:0]      cfg_o,
   output logic [1:0]      uv_threshold_select_o
);
   // Reserved bits are masked off and read as zero
   always_ff @(posedge clk_sys_i or negedge nv_rst_n_i)
   begin
      if (!nv_rst_n_i)
         cfg_o <= NV_PRESET;
      else if (wr_i)
         cfg_o <= wdata_i & NV_WR_MASK;
   end

   // Start-up threshold; fixed at 90 % for the low-voltage variant
   always_ff @(posedge clk_sys_i or negedge nv_rst_n_i)
   begin
      if (!nv_rst_n_i)
         uv_threshold_select_o <= UV_90PCT;
      else if (LOW_VOLT_VARIANT)
         uv_threshold_select_o <= UV_90PCT;
      else
         uv_threshold_select_o <= cfg_o[NV_UV_LSB +: 2];
   end
endmodule // sbcwd_nvcfg
`default_nettype wire

// ### sbcwd_supervisor.sv
/*
 Watchdog supervisor: control, status and configuration registers, mode
 decode, trigger checking, failure flag, reset and wake-up requests.
 Assumes the surrounding chip reports its operating mode, performs the
 requested resets and drives rst_n_i on every system reset.
*/
`timescale 1ns/1ns
`default_nettype none
module sbcwd_supervisor
   import sbcwd_pkg::*;
#(
   parameter int unsigned CYC_PER_MS       = CYC_PER_MS_DFLT,
   parameter bit          LOW_VOLT_VARIANT = 1'b0
)(
   input  wire logic            clk_sys_i,
   input  wire logic            rst_n_i,
   input  wire logic            nv_rst_n_i,
   input  wire logic            reg_wr_i,
   input  wire logic            reg_rd_i,
   input  wire logic [6:0]      reg_addr_i,
   input  wire logic [7:0]      reg_wdata_i,
   input  wire sbcwd_sbc_mode_t sbc_mode_i,
   input  wire logic            rxd_low_i,
   input  wire logic            wake_event_i,
   input  wire logic            spi_fail_en_i,
   input  wire logic            wdf_clear_i,
   output logic [7:0]           reg_rdata_o,
   output logic                 reset_req_o,
   output logic [4:0]           reset_cause_o,
   output logic                 serial_failure_event_o,
   output logic                 guard_failure_flag_o,
   output logic                 wake_o,
   output logic                 rxd_force_low_o,
   output logic                 v1_on_req_o,
   output logic                 to_standby_o,
   output logic                 sleep_command_block_o,
   output logic [1:0]           uv_threshold_select_o
);
   logic [7:0]          nv_cfg;
   logic [2:0]          guard_mode_select;
   logic [3:0]          guard_period_select;
   logic [1:0]          guard_phase_state;
   logic                init_pending;
   sbcwd_behav_t        behav;
   sbcwd_behav_t        next_behav;
   logic                forced_normal_operation;
   logic                sw_dev_operation;
   logic                wr_ctrl;
   logic                code_ok;
   logic                cfg_changed;
   logic                illegal_chg;
   logic                trigger;
   logic                early;
   logic                ovf;
   logic                second_half;
   logic [PERIOD_W-1:0] ms_cnt;
   logic                rxd_low_eff;
   logic                auto_wake;
   logic                tmo_ovf;
   logic                sleep_ovf;
   logic                wd_reset;
   logic [4:0]          next_cause;
   logic [2:0]          new_mode;
   logic [3:0]          new_period;

   sbcwd_nvcfg #(
      .LOW_VOLT_VARIANT (LOW_VOLT_VARIANT)
   ) u_nvcfg (
      .clk_sys_i             (clk_sys_i),
      .nv_rst_n_i            (nv_rst_n_i),
      .wr_i                  (reg_wr_i && (reg_addr_i == ADDR_NV_CFG)),
      .wdata_i               (reg_wdata_i),
      .cfg_o                 (nv_cfg),
      .uv_threshold_select_o (uv_threshold_select_o)
   );

   sbcwd_timer #(
      .CYC_PER_MS (CYC_PER_MS)
   ) u_timer (
      .clk_sys_i     (clk_sys_i),
      .rst_n_i       (rst_n_i),
      .run_i         (behav != SBCWD_OFF),
      .restart_i     (trigger || auto_wake || (behav != next_behav)),
      .period_ms_i   (sbcwd_period_ms(guard_period_select)),
      .ovf_o         (ovf),
      .second_half_o (second_half),
      .ms_cnt_o      (ms_cnt)
   );

   assign sleep_command_block_o = nv_cfg[NV_SLP_BIT];
   assign forced_normal_operation = nv_cfg[NV_FN_BIT];
   // Forced-normal takes precedence over software-development
   assign sw_dev_operation = nv_cfg[NV_SD_BIT] && !nv_cfg[NV_FN_BIT];

   // Control write checking
   assign new_mode    = reg_wdata_i[MODE_LSB +: 3];
   assign new_period  = reg_wdata_i[PER_LSB +: 4];
   assign wr_ctrl     = reg_wr_i && (reg_addr_i == ADDR_WD_CTRL) && !init_pending;
   assign code_ok     = sbcwd_mode_ok(new_mode) && (sbcwd_period_ms(new_period) != 13'h0);
   assign cfg_changed = (new_mode != guard_mode_select) || (new_period != guard_period_select);
   assign illegal_chg = wr_ctrl && code_ok && cfg_changed
                        && (sbc_mode_i == SBCWD_NORMAL);
   assign trigger     = wr_ctrl && code_ok && !illegal_chg;
   assign early       = trigger && (behav == SBCWD_WIN) && !second_half;

   assign rxd_low_eff = rxd_low_i || rxd_force_low_o;
   assign auto_wake   = wake_event_i && (guard_mode_select == MODE_AUTO);
   assign tmo_ovf     = ovf && (behav == SBCWD_TMO);
   assign sleep_ovf   = tmo_ovf && (sbc_mode_i == SBCWD_SLEEP);
   assign wd_reset    = illegal_chg || early || (ovf && (behav == SBCWD_WIN))
                        || (tmo_ovf && !sleep_ovf && guard_failure_flag_o);

   // Behaviour selection from mode code and chip mode
   always_comb
   begin
      next_behav = SBCWD_OFF;
      // Held off until the start-up mode is loaded
      if (forced_normal_operation || init_pending)
         next_behav = SBCWD_OFF;
      else
         case (guard_mode_select)
            MODE_WIN:
               if (sbc_mode_i == SBCWD_NORMAL)
                  next_behav = SBCWD_WIN;
               else if (sbc_mode_i != SBCWD_OTHER)
                  next_behav = SBCWD_TMO;
            MODE_TMO:
               if (sbc_mode_i != SBCWD_OTHER)
                  next_behav = SBCWD_TMO;
            MODE_AUTO:
               if (!sw_dev_operation && ((sbc_mode_i == SBCWD_NORMAL)
                   || ((sbc_mode_i == SBCWD_STANDBY) && rxd_low_eff)))
                  next_behav = SBCWD_TMO;
            default:
               next_behav = SBCWD_OFF;
         endcase
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         behav <= SBCWD_OFF;
      else
         behav <= next_behav;
   end

   // Mode and period; the default mode is chosen once after reset release
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         init_pending        <= 1'b1;
         guard_mode_select   <= MODE_TMO;
         guard_period_select <= PER_128;
      end
      else if (init_pending)
      begin
         init_pending      <= 1'b0;
         guard_mode_select <= sw_dev_operation ? MODE_AUTO : MODE_TMO;
      end
      else if (trigger)
      begin
         guard_mode_select   <= new_mode;
         guard_period_select <= new_period;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         serial_failure_event_o <= 1'b0;
      else
         serial_failure_event_o <= spi_fail_en_i
                                   && ((wr_ctrl && !code_ok) || illegal_chg);
   end

   // Failure flag: a new overflow wins over a clear in the same cycle
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         guard_failure_flag_o <= 1'b0;
      else if (tmo_ovf)
         guard_failure_flag_o <= 1'b1;
      else if (wdf_clear_i)
         guard_failure_flag_o <= 1'b0;
   end

   always_comb
   begin
      next_cause = CAUSE_OVF;
      if (illegal_chg)
         next_cause = CAUSE_ILLEGAL;
      else if (early)
         next_cause = CAUSE_EARLY;
      else if (sleep_ovf)
         next_cause = CAUSE_SLP_OVF;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         reset_req_o <= 1'b0;
      else
         reset_req_o <= wd_reset;
   end

   // Cause survives system resets; cleared only at power-on
   always_ff @(posedge clk_sys_i or negedge nv_rst_n_i)
   begin
      if (!nv_rst_n_i)
         reset_cause_o <= CAUSE_POWER;
      else if (wd_reset || sleep_ovf)
         reset_cause_o <= next_cause;
   end

   // Wake-up side effects
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wake_o          <= 1'b0;
         rxd_force_low_o <= 1'b0;
         v1_on_req_o     <= 1'b0;
         to_standby_o    <= 1'b0;
      end
      else
      begin
         wake_o       <= sleep_ovf;
         to_standby_o <= auto_wake && (sbc_mode_i == SBCWD_SLEEP);
         if (sleep_ovf || auto_wake)
            rxd_force_low_o <= 1'b1;
         else if (sbc_mode_i == SBCWD_NORMAL)
            rxd_force_low_o <= 1'b0;
         if (sleep_ovf)
            v1_on_req_o <= 1'b1;
         else if (sbc_mode_i != SBCWD_SLEEP)
            v1_on_req_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         guard_phase_state <= WDS_OFF;
      else if (next_behav == SBCWD_OFF)
         guard_phase_state <= WDS_OFF;
      else if (second_half)
         guard_phase_state <= WDS_SECOND;
      else
         guard_phase_state <= WDS_FIRST;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         reg_rdata_o <= 8'h00;
      else if (reg_rd_i)
         case (reg_addr_i)
            ADDR_WD_CTRL: reg_rdata_o <= {guard_mode_select, 1'b0, guard_period_select};
            ADDR_WD_STAT: reg_rdata_o <= {4'h0, forced_normal_operation,
                                          sw_dev_operation, guard_phase_state};
            ADDR_NV_CFG:  reg_rdata_o <= nv_cfg;
            default:      reg_rdata_o <= 8'h00;
         endcase
   end

   default clocking dflt_cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence sleep_expiry_s;
      sleep_ovf;
   endsequence

   sequence wake_effects_s;
      wake_o && rxd_force_low_o && v1_on_req_o && guard_failure_flag_o;
   endsequence

   bad_code_drop_a: assert property (wr_ctrl && !code_ok |=>
      $stable(guard_mode_select) && $stable(guard_period_select)
      && (serial_failure_event_o == $past(spi_fail_en_i)))
      else $error("invalid control code not discarded");
   forced_off_a: assert property (forced_normal_operation |=> behav == SBCWD_OFF)
      else $error("watchdog running under forced-normal");
   sdm_default_a: assert property (init_pending && sw_dev_operation |=>
      guard_mode_select == MODE_AUTO)
      else $error("autonomous default not loaded");
   early_reset_a: assert property (early |=> reset_req_o
      && reset_cause_o == CAUSE_EARLY)
      else $error("early window trigger not reset");
   window_ok_a: assert property (trigger && behav == SBCWD_WIN && second_half
      |=> !reset_req_o ##1 ms_cnt == 13'h0)
      else $error("valid window trigger mishandled");
   first_ovf_a: assert property (tmo_ovf && !sleep_ovf && !guard_failure_flag_o
      |=> guard_failure_flag_o && !reset_req_o)
      else $error("first timeout overflow mishandled");
   second_ovf_a: assert property (tmo_ovf && !sleep_ovf && guard_failure_flag_o
      |=> reset_req_o && reset_cause_o == CAUSE_OVF)
      else $error("pending failure overflow did not reset");
   sleep_wake_a: assert property (sleep_expiry_s |=> wake_effects_s)
      else $error("sleep expiry wake effects missing");
   illegal_cfg_a: assert property (illegal_chg |=> reset_req_o
      && reset_cause_o == CAUSE_ILLEGAL && $stable(guard_mode_select))
      else $error("normal-mode reconfiguration not caught");
   phase_code_a: assert property (behav == SBCWD_OFF ##1 behav == SBCWD_OFF
      |-> guard_phase_state == WDS_OFF)
      else $error("phase state not off while stopped");
   auto_wake_a: assert property (auto_wake |=> rxd_force_low_o
      && (to_standby_o == ($past(sbc_mode_i) == SBCWD_SLEEP)))
      else $error("autonomous wake-up not signalled");
   auto_sdm_off_a: assert property (guard_mode_select == MODE_AUTO
      && sw_dev_operation |=> behav == SBCWD_OFF)
      else $error("autonomous watchdog running in development mode");
endmodule // sbcwd_supervisor
`default_nettype wire

// ### sbcwd_host.sv
/* Host model: microcontroller side of the register port and flag clear.
   Assumes calls come from one process; signals change just after a rising edge. */
`timescale 1ns/1ns
`default_nettype none
module sbcwd_host
(
   input  wire logic       clk_sys_i,
   input  wire logic [7:0] rdata_i,
   output logic            wr_o,
   output logic            rd_o,
   output logic [6:0]      addr_o,
   output logic [7:0]      wdata_o,
   output logic            clr_o
);
   initial
   begin
      wr_o = 1'b0;
      rd_o = 1'b0;
      clr_o = 1'b0;
      addr_o = 7'h7f;
      wdata_o = 8'h00;
   end
   // A valid control write is a trigger unless it changes the config in Normal; mode changes are meant to be issued from Standby
   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      @(posedge clk_sys_i);
      #1;
      addr_o = a;
      wdata_o = v;
      wr_o = 1'b1;
      @(posedge clk_sys_i);
      #1;
      wr_o = 1'b0;
      wdata_o = ~v;
   endtask
   task automatic rd(input logic [6:0] a, output logic [7:0] v);
      @(posedge clk_sys_i);
      #1;
      addr_o = a;
      rd_o = 1'b1;
      @(posedge clk_sys_i);
      #1;
      rd_o = 1'b0;
      v = rdata_i;
   endtask
   // Software clears the failure flag before triggering again
   task automatic clear();
      @(posedge clk_sys_i);
      #1;
      clr_o = 1'b1;
      @(posedge clk_sys_i);
      #1;
      clr_o = 1'b0;
   endtask
endmodule // sbcwd_host
`default_nettype wire

// ### sbcwd_supervisor_test.sv
/* Self-checking testbench of the watchdog supervisor with a host model.
   Assumes a prescaler of 10 cycles per ms, so an 8 ms period is 80 cycles. */
`timescale 1ns/1ns
`default_nettype none
module sbcwd_supervisor_test
   import sbcwd_pkg::*;
;
   logic            clk = 1'b0, rst_n = 1'b0, nv_rst_n = 1'b0;
   logic            spi_en = 1'b1, rxd_low = 1'b0, wake = 1'b0;
   sbcwd_sbc_mode_t mode = SBCWD_STANDBY;
   logic            wr, rd, clr, rst_req, sfe, guard_failure_flag, wk, rxd_f, v1, slp_blk, stby;
   logic [1:0]      uv;
   logic [6:0]      addr;
   logic [7:0]      wdata, rdata, d, nvm;
   logic [4:0]      cause;
   int              n_fail = 0, total_checks = 0, n;

   sbcwd_supervisor #(.CYC_PER_MS(10)) u_dut (.clk_sys_i(clk), .rst_n_i(rst_n),
      .nv_rst_n_i(nv_rst_n), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .sbc_mode_i(mode), .rxd_low_i(rxd_low), .wake_event_i(wake),
      .spi_fail_en_i(spi_en), .wdf_clear_i(clr), .reg_rdata_o(rdata),
      .reset_req_o(rst_req), .reset_cause_o(cause), .serial_failure_event_o(sfe),
      .guard_failure_flag_o(guard_failure_flag), .wake_o(wk), .rxd_force_low_o(rxd_f),
      .v1_on_req_o(v1), .to_standby_o(stby), .sleep_command_block_o(slp_blk),
      .uv_threshold_select_o(uv));
   sbcwd_host u_host (.clk_sys_i(clk), .rdata_i(rdata), .wr_o(wr), .rd_o(rd),
      .addr_o(addr), .wdata_o(wdata), .clr_o(clr));

   always #5 clk = ~clk;

   // Expected status from the shadow of the configuration register
   function automatic logic [7:0] stat(input logic [1:0] ph);
      return {4'h0, nvm[3], nvm[2] & ~nvm[3], ph};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      if (n_fail == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   // Waits for 0 reset request, 1 failure flag, 2 wake-up; n counts cycles
   task automatic wait_ev(input int w);
      n = 0;
      while (!((w == 0) ? rst_req === 1'b1 : (w == 1) ? guard_failure_flag === 1'b1 : wk === 1'b1))
      begin
         tick(1);
         n++;
         if (n > 3000)
         begin
            n_fail++;
            final_report();
         end
      end
   endtask

   initial
   begin
      void'($urandom(32'hb42d));
      nvm = 8'h08;
      tick(3);
      rst_n = 1'b1;
      nv_rst_n = 1'b1;
      tick(2);
      u_host.rd(ADDR_NV_CFG, d);
      chk(d, 8'h08);
      u_host.rd(ADDR_WD_STAT, d);
      chk(d, stat(WDS_OFF));
      nvm = {2'h0, 2'($urandom), 4'h1};
      u_host.wr(ADDR_NV_CFG, nvm | 8'hc2);
      u_host.rd(ADDR_NV_CFG, d);
      chk(d, nvm);
      chk({6'h0, uv}, {6'h0, nvm[5:4]});
      chk({7'h0, slp_blk}, 8'h01);
      for (int i = 0; i < 2; i++)
      begin
         u_host.wr(ADDR_WD_CTRL, (i == 0) ? 8'h68 : 8'h49);
         chk({6'h0, sfe, rst_req}, 8'h02);
      end
      u_host.clear();
      for (int i = 0; i < 3; i++)
      begin
         tick($urandom_range(70, 10));
         u_host.wr(ADDR_WD_CTRL, 8'h48);
         chk({7'h0, guard_failure_flag}, 8'h00);
      end
      wait_ev(1);
      chk({7'h0, n >= 78 && n <= 83}, 8'h01);
      tick(8);
      u_host.rd(ADDR_WD_STAT, d);
      chk(d, stat(WDS_FIRST));
      tick(40);
      u_host.rd(ADDR_WD_STAT, d);
      chk(d, stat(WDS_SECOND));
      wait_ev(0);
      chk({3'h0, cause}, {3'h0, CAUSE_OVF});
      u_host.wr(ADDR_WD_CTRL, 8'h88);
      mode = SBCWD_NORMAL;
      tick($urandom_range(70, 50));
      u_host.wr(ADDR_WD_CTRL, 8'h88);
      chk({7'h0, rst_req}, 8'h00);
      wait_ev(0);
      chk({3'h0, cause}, {3'h0, CAUSE_OVF});
      chk({7'h0, n >= 78 && n <= 83}, 8'h01);
      tick(20);
      u_host.wr(ADDR_WD_CTRL, 8'h88);
      chk({2'h0, rst_req, cause}, {2'h0, 1'b1, CAUSE_EARLY});
      u_host.wr(ADDR_WD_CTRL, 8'h44);
      chk({1'b0, sfe, rst_req, cause}, {2'h1, 1'b1, CAUSE_ILLEGAL});
      nvm = 8'h08;
      u_host.wr(ADDR_NV_CFG, nvm);
      tick(100);
      u_host.rd(ADDR_WD_STAT, d);
      chk(d, stat(WDS_OFF));
      nvm = 8'h00;
      u_host.wr(ADDR_NV_CFG, nvm);
      mode = SBCWD_STANDBY;
      u_host.wr(ADDR_WD_CTRL, 8'h48);
      mode = SBCWD_SLEEP;
      u_host.clear();
      wait_ev(2);
      chk({4'h0, rxd_f, v1, guard_failure_flag, rst_req}, 8'h0e);
      chk({3'h0, cause}, {3'h0, CAUSE_SLP_OVF});
      mode = SBCWD_STANDBY;
      nvm = 8'h04;
      u_host.wr(ADDR_NV_CFG, nvm);
      rst_n = 1'b0;
      tick(3);
      rst_n = 1'b1;
      tick(2);
      u_host.rd(ADDR_WD_CTRL, d);
      chk(d, {MODE_AUTO, 1'b0, PER_128});
      u_host.rd(ADDR_WD_STAT, d);
      chk(d, stat(WDS_OFF));
      nvm = 8'h00;
      u_host.wr(ADDR_NV_CFG, nvm);
      u_host.rd(ADDR_WD_STAT, d);
      chk(d, stat(WDS_OFF));
      mode = SBCWD_SLEEP;
      wake = 1'b1;
      tick(1);
      wake = 1'b0;
      chk({6'h0, stby, rxd_f}, 8'h03);
      mode = SBCWD_STANDBY;
      tick(2);
      chk({7'h0, stby}, 8'h00);
      u_host.rd(ADDR_WD_STAT, d);
      chk(d, stat(WDS_FIRST));
      final_report();
   end
endmodule // sbcwd_supervisor_test
`default_nettype wire
